//--- design/fpmc_top.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Sessions open with a menu press, close with a confirmed press at save prompt.
// - Any session not closed by a confirmed save discards its changes.
// - About thirty seconds without switch activity abandons the session and restores.
// - Committed settings live in non-volatile store and reload at power return.
// - Power-up shows all segments, then version, then runs.
// - Horizontal switch moves the cursor one place left or right.
// - In gain editing the vertical switch raises or lowers the cursor digit.
// - On/off items toggle on every vertical actuation, whatever the direction.
// - Edited gain applies at once, stored only after a yes at save prompt.
// - Gain steps of 0.5, 1 and 10 dB follow the cursor digit.
// - Yes commits session settings; no restores the settings held before it.
// - Return item or passing the last menu leads to the save prompt.
// - Seven items in order: gain, mute, ref mode, offset, remote, interface, address.
// - A menu press while a value shows advances to the next item.
// - Alarm output and LED light while any oscillator reports loss of lock.
// - Remote LED lights while remote control is selected.
// - Internal mode selects the built-in oven oscillator and the internal tag.
// - External mode selects the external input and the external tag.
// - Auto mode uses external while its level is good, tag auto-external.
// - Auto mode falls to internal on low external level, tag auto-internal.
// - Gain is held in tenths of a decibel, clamped to 0 through 300.
module fpmc_top #(
  parameter logic [fpmc_pkg::TMR_W-1:0] TIMEOUT_CYC = fpmc_pkg::TMR_W'(fpmc_pkg::TIMEOUT_CYC),
  parameter logic [31:0]                PHASE_CYC   = 32'(fpmc_pkg::PHASE_CYC),
  parameter logic [31:0]                DEB_CYC     = 32'(fpmc_pkg::DEB_CYC)
) (
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_N_I,
  input  wire logic [11:0]              S_AXI_AWADDR_I,
  input  wire logic                     S_AXI_AWVALID_I,
  output logic                          S_AXI_AWREADY_O,
  input  wire logic [31:0]              S_AXI_WDATA_I,
  input  wire logic [3:0]               S_AXI_WSTRB_I,
  input  wire logic                     S_AXI_WVALID_I,
  output logic                          S_AXI_WREADY_O,
  output logic [1:0]                    S_AXI_BRESP_O,
  output logic                          S_AXI_BVALID_O,
  input  wire logic                     S_AXI_BREADY_I,
  input  wire logic [11:0]              S_AXI_ARADDR_I,
  input  wire logic                     S_AXI_ARVALID_I,
  output logic                          S_AXI_ARREADY_O,
  output logic [31:0]                   S_AXI_RDATA_O,
  output logic [1:0]                    S_AXI_RRESP_O,
  output logic                          S_AXI_RVALID_O,
  input  wire logic                     S_AXI_RREADY_I,
  input  wire logic                     SW_MENU_I,
  input  wire logic                     SW_LEFT_I,
  input  wire logic                     SW_RIGHT_I,
  input  wire logic                     SW_UP_I,
  input  wire logic                     SW_DOWN_I,
  input  wire logic [1:0]               LO_LOCK_I,
  input  wire logic                     EXT_LOW_I,
  input  wire fpmc_pkg::fpmc_settings_t NV_DATA_I,
  output logic                          NV_WR_O,
  output fpmc_pkg::fpmc_settings_t      NV_DATA_O,
  output fpmc_pkg::fpmc_settings_t      SETTINGS_O,
  output fpmc_pkg::fpmc_disp_t          DISP_O,
  output logic                          ALARM_O,
  output logic                          ALARM_LED_O,
  output logic                          REMOTE_LED_O,
  output logic                          REF_SEL_EXT_O
);
  import fpmc_pkg::*;

  localparam int unsigned NIN = 8;

  logic [NIN-1:0]       raw_in;
  logic [NIN-1:0]       s1_q, s2_q, s3_q, stable_q;
  logic [4:0]           sw_prev_q;
  logic [4:0]           sw_ev;
  logic                 ev_menu, ev_left, ev_right, ev_up, ev_down, any_ev;
  logic                 ext_low_db_q;
  logic [31:0]          deb_cnt_q;
  fpmc_phase_t          phase_q;
  logic [31:0]          phase_cnt_q;
  logic                 nv_loaded_q;
  fpmc_state_t          state_q;
  logic [2:0]           item_q;
  logic [1:0]           cursor_q;
  logic                 save_yes_q;
  logic [TMR_W-1:0]     tmr_q;
  fpmc_settings_t       live_q, saved_q;
  logic                 lock_q;
  logic [1:0]           cur_last;
  logic                 timeout;
  fpmc_tag_t            tag_d;
  logic                 external_ref_tag_d;
  logic                 aw_held_q, w_held_q;
  logic [11:0]          awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 wr_go;

  // Input synchronisers: a level is taken once the second and third stages agree
  assign raw_in = {EXT_LOW_I, LO_LOCK_I, SW_DOWN_I, SW_UP_I, SW_RIGHT_I, SW_LEFT_I, SW_MENU_I};

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1_q     <= 8'h60;
      s2_q     <= 8'h60;
      s3_q     <= 8'h60;
      stable_q <= 8'h60;
    end else begin
      s1_q     <= raw_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sw_prev_q <= '0;
    end else begin
      sw_prev_q <= stable_q[4:0];
    end
  end

  // Switch events are ignored during power-up and while software locks the panel
  assign sw_ev    = (phase_q == PH_RUN && !lock_q) ? (stable_q[4:0] & ~sw_prev_q) : 5'h00;
  assign ev_menu  = sw_ev[0];
  assign ev_left  = sw_ev[1];
  assign ev_right = sw_ev[2];
  assign ev_up    = sw_ev[3];
  assign ev_down  = sw_ev[4];
  assign any_ev   = |sw_ev;

  // External low-level flag must hold its new value for the debounce time
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      deb_cnt_q    <= '0;
      ext_low_db_q <= 1'b0;
    end else if (stable_q[7] == ext_low_db_q) begin
      deb_cnt_q    <= '0;
    end else if (deb_cnt_q >= DEB_CYC - 32'h1) begin
      deb_cnt_q    <= '0;
      ext_low_db_q <= stable_q[7];
    end else begin
      deb_cnt_q    <= deb_cnt_q + 32'h1;
    end
  end

  // Power-up display sequence
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phase_q     <= PH_LAMP;
      phase_cnt_q <= '0;
    end else if (phase_q != PH_RUN) begin
      if (phase_cnt_q >= PHASE_CYC - 32'h1) begin
        phase_cnt_q <= '0;
        phase_q     <= (phase_q == PH_LAMP) ? PH_VER : PH_RUN;
      end else begin
        phase_cnt_q <= phase_cnt_q + 32'h1;
      end
    end
  end

  // Return position of the cursor for the current item
  assign cur_last = (item_q == IT_GAIN || item_q == IT_OFS) ? CUR_R_DIGITS : CUR_R_SINGLE;
  assign timeout  = (state_q != ST_IDLE) && (tmr_q == TMR_W'(1)) && !any_ev;

  // Inactivity timer
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tmr_q <= '0;
    end else if (state_q == ST_IDLE && !ev_menu) begin
      tmr_q <= '0;
    end else if (any_ev) begin
      tmr_q <= TIMEOUT_CYC;
    end else if (tmr_q != '0) begin
      tmr_q <= tmr_q - TMR_W'(1);
    end
  end

  // Menu sequencing
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q    <= ST_IDLE;
      item_q     <= IT_GAIN;
      cursor_q   <= '0;
      save_yes_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ev_menu) begin
            state_q  <= ST_EDIT;
            item_q   <= IT_GAIN;
            cursor_q <= '0;
          end
        end
        ST_EDIT: begin
          if (timeout) begin
            state_q <= ST_IDLE;
          end else if (ev_menu) begin
            cursor_q <= '0;
            if (cursor_q == cur_last || item_q == IT_ADDR) begin
              state_q    <= ST_SAVE;
              save_yes_q <= 1'b0;
            end else begin
              item_q <= item_q + 3'h1;
            end
          end else if (ev_left && cursor_q != '0) begin
            cursor_q <= cursor_q - 2'h1;
          end else if (ev_right && cursor_q != cur_last) begin
            cursor_q <= cursor_q + 2'h1;
          end
        end
        ST_SAVE: begin
          if (timeout || ev_menu) begin
            state_q <= ST_IDLE;
          end else if (ev_up || ev_down || ev_left || ev_right) begin
            save_yes_q <= !save_yes_q;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  function automatic logic [9:0] gain_step(input logic [9:0] g, input logic [1:0] pos,
                                           input logic up);
    logic [10:0] d;
    logic [10:0] r;
    d = (pos == 2'h0) ? STEP_10DB : (pos == 2'h1) ? STEP_1DB : STEP_HALF;
    if (up) begin
      r = {1'b0, g} + d;
      if (r > GAIN_MAX) begin
        r = GAIN_MAX;
      end
    end else begin
      r = ({1'b0, g} < d) ? 11'h000 : ({1'b0, g} - d);
    end
    return r[9:0];
  endfunction : gain_step

  function automatic logic [11:0] ofs_step(input logic signed [11:0] o, input logic [1:0] pos,
                                           input logic up);
    logic signed [12:0] d;
    logic signed [12:0] r;
    d = (pos == 2'h0) ? OFS_S0 : (pos == 2'h1) ? OFS_S1 : OFS_S2;
    r = up ? (13'(o) + d) : (13'(o) - d);
    if (r > OFS_MAX) begin
      r = OFS_MAX;
    end else if (r < OFS_MIN) begin
      r = OFS_MIN;
    end
    return r[11:0];
  endfunction : ofs_step

  // Live settings: edits apply at once, timeout or no restores the saved copy
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      live_q <= SETTINGS_RST;
    end else if (!nv_loaded_q) begin
      live_q <= NV_DATA_I;
    end else if (timeout) begin
      live_q <= saved_q;
    end else if (state_q == ST_SAVE && ev_menu && !save_yes_q) begin
      live_q <= saved_q;
    end else if (state_q == ST_EDIT && (ev_up || ev_down) && cursor_q != cur_last) begin
      case (item_q)
        IT_GAIN: live_q.gain       <= gain_step(live_q.gain, cursor_q, ev_up);
        IT_MUTE: live_q.mute       <= !live_q.mute;
        IT_REFM: begin
          case (live_q.ref_mode)
            REF_INT: live_q.ref_mode <= ev_up ? EXTERNAL_REF_TAG : REF_AUTO;
            EXTERNAL_REF_TAG: live_q.ref_mode <= ev_up ? REF_AUTO : REF_INT;
            default: live_q.ref_mode <= ev_up ? REF_INT : EXTERNAL_REF_TAG;
          endcase
        end
        IT_OFS:  live_q.ref_offset <= ofs_step(live_q.ref_offset, cursor_q, ev_up);
        IT_REM:  live_q.remote_en  <= !live_q.remote_en;
        IT_RIF:  live_q.remote_if  <= !live_q.remote_if;
        IT_ADDR: live_q.bus_addr   <= ev_up ? live_q.bus_addr + 5'h01
                                            : live_q.bus_addr - 5'h01;
        default: live_q <= live_q;
      endcase
    end
  end

  // Committed copy and non-volatile write
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nv_loaded_q <= 1'b0;
      saved_q     <= SETTINGS_RST;
      NV_WR_O     <= 1'b0;
      NV_DATA_O   <= SETTINGS_RST;
    end else begin
      nv_loaded_q <= 1'b1;
      NV_WR_O     <= 1'b0;
      if (!nv_loaded_q) begin
        saved_q <= NV_DATA_I;
        NV_DATA_O <= NV_DATA_I;
      end else if (state_q == ST_SAVE && ev_menu && save_yes_q && !timeout) begin
        saved_q   <= live_q;
        NV_DATA_O <= live_q;
        NV_WR_O   <= 1'b1;
      end
    end
  end

  // Reference source selection and display tag
  always_comb begin
    case (live_q.ref_mode)
      REF_INT: begin
        external_ref_tag_d = 1'b0;
        tag_d     = TAG_INT;
      end
      EXTERNAL_REF_TAG: begin
        external_ref_tag_d = 1'b1;
        tag_d     = TAG_EXT;
      end
      default: begin
        external_ref_tag_d = !ext_low_db_q;
        tag_d     = ext_low_db_q ? TAG_AUTO_I : TAG_AUTO_E;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REF_SEL_EXT_O <= 1'b0;
      ALARM_O       <= 1'b0;
      ALARM_LED_O   <= 1'b0;
      REMOTE_LED_O  <= 1'b0;
      SETTINGS_O    <= SETTINGS_RST;
      DISP_O        <= '0;
    end else begin
      REF_SEL_EXT_O   <= external_ref_tag_d;
      ALARM_O         <= !(&stable_q[6:5]);
      ALARM_LED_O     <= !(&stable_q[6:5]);
      REMOTE_LED_O    <= live_q.remote_en;
      SETTINGS_O      <= live_q;
      DISP_O.phase    <= phase_q;
      DISP_O.state    <= state_q;
      DISP_O.save_yes <= save_yes_q;
      DISP_O.item     <= item_q;
      DISP_O.cursor   <= cursor_q;
      DISP_O.tag      <= tag_d;
    end
  end

  // AXI4-Lite write channel
  assign S_AXI_AWREADY_O = !aw_held_q && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_held_q && !S_AXI_BVALID_O;
  assign wr_go           = aw_held_q && w_held_q && !S_AXI_BVALID_O;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held_q      <= 1'b0;
      w_held_q       <= 1'b0;
      awaddr_q       <= '0;
      wdata_q        <= '0;
      wstrb_q        <= '0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA_I;
        wstrb_q  <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        aw_held_q      <= 1'b0;
        w_held_q       <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        case ({awaddr_q[11:2], 2'b00})
          REG_STATUS, REG_LIVE, REG_SAVED, REG_CTRL: S_AXI_BRESP_O <= RESP_OKAY;
          default:                                   S_AXI_BRESP_O <= RESP_SLVERR;
        endcase
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Control register: panel lock
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lock_q <= 1'b0;
    end else if (wr_go && {awaddr_q[11:2], 2'b00} == REG_CTRL && wstrb_q[0]) begin
      lock_q <= wdata_q[CTRL_LOCK_BIT];
    end
  end

  // AXI4-Lite read channel
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= '0;
      S_AXI_RRESP_O  <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O  <= RESP_OKAY;
      case ({S_AXI_ARADDR_I[11:2], 2'b00})
        REG_STATUS: S_AXI_RDATA_O <= {16'h0000, ext_low_db_q, !(&stable_q[6:5]),
                                      DISP_O.phase, DISP_O.state, DISP_O.save_yes,
                                      DISP_O.item, DISP_O.cursor, DISP_O.tag,
                                      1'b0, REF_SEL_EXT_O};
        REG_LIVE:   S_AXI_RDATA_O <= live_q;
        REG_SAVED:  S_AXI_RDATA_O <= saved_q;
        REG_CTRL:   S_AXI_RDATA_O <= {31'h00000000, lock_q};
        default: begin
          S_AXI_RDATA_O <= '0;
          S_AXI_RRESP_O <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule : fpmc_top

`default_nettype wire

//--- design/fpmc_pkg.sv
package fpmc_pkg;

  // Clock rate and derived cycle counts
  localparam int unsigned      CLK_MHZ     = 200;
  localparam longint unsigned  TIMEOUT_S   = 30;
  localparam longint unsigned  TIMEOUT_CYC = TIMEOUT_S * CLK_MHZ * 64'd1000000;
  localparam int unsigned      PHASE_MS    = 1000;
  localparam int unsigned      PHASE_CYC   = PHASE_MS * CLK_MHZ * 1000;
  localparam int unsigned      DEB_US      = 1000;
  localparam int unsigned      DEB_CYC     = DEB_US * CLK_MHZ;
  localparam int unsigned      TMR_W       = 33;

  // Gain limits and steps, in tenths of a decibel
  localparam logic [10:0] GAIN_MAX  = 11'h12c;
  localparam logic [10:0] STEP_10DB = 11'h064;
  localparam logic [10:0] STEP_1DB  = 11'h00a;
  localparam logic [10:0] STEP_HALF = 11'h005;
  // Reference offset limits and steps
  localparam logic signed [12:0] OFS_MAX = 13'sh07d0;
  localparam logic signed [12:0] OFS_MIN = -13'sh07d0;
  localparam logic signed [12:0] OFS_S0  = 13'sh0064;
  localparam logic signed [12:0] OFS_S1  = 13'sh000a;
  localparam logic signed [12:0] OFS_S2  = 13'sh0001;

  // Menu items in presentation order
  localparam logic [2:0] IT_GAIN = 3'h0;
  localparam logic [2:0] IT_MUTE = 3'h1;
  localparam logic [2:0] IT_REFM = 3'h2;
  localparam logic [2:0] IT_OFS  = 3'h3;
  localparam logic [2:0] IT_REM  = 3'h4;
  localparam logic [2:0] IT_RIF  = 3'h5;
  localparam logic [2:0] IT_ADDR = 3'h6;
  localparam logic [1:0] CUR_R_DIGITS = 2'h3;
  localparam logic [1:0] CUR_R_SINGLE = 2'h1;

  // Register map, byte addresses
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_LIVE   = 12'h004;
  localparam logic [11:0] REG_SAVED  = 12'h008;
  localparam logic [11:0] REG_CTRL   = 12'h00c;
  localparam int unsigned CTRL_LOCK_BIT = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REF_INT  = 2'b00,
    EXTERNAL_REF_TAG  = 2'b01,
    REF_AUTO = 2'b10
  } fpmc_refmode_t;

  typedef enum logic [1:0] {
    TAG_INT    = 2'b00,
    TAG_EXT    = 2'b01,
    TAG_AUTO_E = 2'b10,
    TAG_AUTO_I = 2'b11
  } fpmc_tag_t;

  typedef enum logic [1:0] {
    PH_LAMP = 2'b00,
    PH_VER  = 2'b01,
    PH_RUN  = 2'b10
  } fpmc_phase_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EDIT = 2'b01,
    ST_SAVE = 2'b10
  } fpmc_state_t;

  typedef struct packed {
    logic [4:0]         bus_addr;
    logic               remote_if;
    logic               remote_en;
    logic signed [11:0] ref_offset;
    fpmc_refmode_t      ref_mode;
    logic               mute;
    logic [9:0]         gain;
  } fpmc_settings_t;

  typedef struct packed {
    fpmc_phase_t phase;
    fpmc_state_t state;
    logic        save_yes;
    logic [2:0]  item;
    logic [1:0]  cursor;
    fpmc_tag_t   tag;
  } fpmc_disp_t;

  localparam fpmc_settings_t SETTINGS_RST = '0;

endpackage : fpmc_pkg

//--- verification/fpmc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_properties (
  input wire logic                     MCLK_I,
  input wire logic                     RST_N_I,
  input wire logic [1:0]               LO_LOCK_I,
  input wire logic                     NV_WR_O,
  input wire fpmc_pkg::fpmc_settings_t NV_DATA_O,
  input wire fpmc_pkg::fpmc_settings_t SETTINGS_O,
  input wire fpmc_pkg::fpmc_disp_t     DISP_O,
  input wire logic                     ALARM_O,
  input wire logic                     ALARM_LED_O,
  input wire logic                     REMOTE_LED_O,
  input wire logic                     REF_SEL_EXT_O
);
  import fpmc_pkg::*;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_lost; (LO_LOCK_I != 2'h3)[*6]; endsequence
  sequence s_held; (LO_LOCK_I == 2'h3)[*6]; endsequence
  sequence s_int; (SETTINGS_O.ref_mode == REF_INT)[*4]; endsequence
  sequence s_ext; (SETTINGS_O.ref_mode == EXTERNAL_REF_TAG)[*4]; endsequence
  sequence s_auto; (SETTINGS_O.ref_mode == REF_AUTO && $stable(REF_SEL_EXT_O))[*4]; endsequence
  property p_alarm_on; s_lost |-> ALARM_O && ALARM_LED_O; endproperty
  property p_alarm_off; s_held |-> !ALARM_O && !ALARM_LED_O; endproperty
  property p_remote; REMOTE_LED_O == SETTINGS_O.remote_en; endproperty
  property p_gain_max; SETTINGS_O.gain <= 10'h12c; endproperty
  property p_int; s_int |-> !REF_SEL_EXT_O && DISP_O.tag == TAG_INT; endproperty
  property p_ext; s_ext |-> REF_SEL_EXT_O && DISP_O.tag == TAG_EXT; endproperty
  property p_auto; s_auto |-> DISP_O.tag == (REF_SEL_EXT_O ? TAG_AUTO_E : TAG_AUTO_I); endproperty
  property p_wr_pulse; NV_WR_O |=> !NV_WR_O ##[0:3] DISP_O.state == ST_IDLE; endproperty
  property p_wr_data; NV_WR_O |-> NV_DATA_O == SETTINGS_O; endproperty
  property p_store; $changed(NV_DATA_O) && DISP_O.phase == PH_RUN |-> NV_WR_O; endproperty
  property p_phase; $changed(DISP_O.phase) |-> DISP_O.phase == 2'($past(DISP_O.phase) + 2'h1);
  endproperty
  property p_boot_idle; DISP_O.phase != PH_RUN |-> DISP_O.state == ST_IDLE; endproperty
  a_alarm_on: assert property (p_alarm_on) else $error("alarm not raised");
  a_alarm_off: assert property (p_alarm_off) else $error("alarm stuck");
  a_remote: assert property (p_remote) else $error("remote led wrong");
  a_gain_max: assert property (p_gain_max) else $error("gain above limit");
  a_int: assert property (p_int) else $error("internal source wrong");
  a_ext: assert property (p_ext) else $error("external source wrong");
  a_auto: assert property (p_auto) else $error("auto tag wrong");
  a_wr_pulse: assert property (p_wr_pulse) else $error("store pulse wrong");
  a_wr_data: assert property (p_wr_data) else $error("stored data wrong");
  a_store: assert property (p_store) else $error("store changed");
  a_phase: assert property (p_phase) else $error("phase order wrong");
  a_boot_idle: assert property (p_boot_idle) else $error("input before run");
endmodule : fpmc_properties
bind fpmc_top fpmc_properties i_props (.MCLK_I, .RST_N_I, .LO_LOCK_I, .NV_WR_O, .NV_DATA_O,
  .SETTINGS_O, .DISP_O, .ALARM_O, .ALARM_LED_O, .REMOTE_LED_O, .REF_SEL_EXT_O);
`default_nettype wire

//--- verification/fpmc_operator.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_operator (
  input  wire logic       clk_i,
  output var logic [4:0]  sw_o
);
  initial sw_o = 5'h00;
  // Order: menu, left, right, up, down; each press is a full press and release
  task automatic press(input int k);
    sw_o[k] <= 1'b1;
    repeat (6) @(posedge clk_i);
    sw_o[k] <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : press
endmodule : fpmc_operator
`default_nettype wire

//--- verification/tb_front_panel_menu_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_front_panel_menu_control;
  import fpmc_pkg::*;
  logic           mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, ext_low;
  logic           awready, wready, bvalid, arready, rvalid, nv_wr, alarm, alarm_led;
  logic           rem_led, external_ref_tag;
  logic [11:0]    awaddr, araddr;
  logic [31:0]    wdata, rdata, d;
  logic [3:0]     wstrb;
  logic [1:0]     bresp, rresp, lo_lock, r;
  logic [4:0]     sw;
  fpmc_settings_t nv_in, nv_out, sets, saved, live;
  fpmc_disp_t     disp;
  int             errors, cmp_count, seed, g, c;

  fpmc_top #(.TIMEOUT_CYC(33'd200), .PHASE_CYC(32'd10), .DEB_CYC(32'd5)) i_dut (
    .MCLK_I(mclk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .SW_MENU_I(sw[0]), .SW_LEFT_I(sw[1]), .SW_RIGHT_I(sw[2]), .SW_UP_I(sw[3]),
    .SW_DOWN_I(sw[4]), .LO_LOCK_I(lo_lock), .EXT_LOW_I(ext_low), .NV_DATA_I(nv_in),
    .NV_WR_O(nv_wr), .NV_DATA_O(nv_out), .SETTINGS_O(sets), .DISP_O(disp), .ALARM_O(alarm),
    .ALARM_LED_O(alarm_led), .REMOTE_LED_O(rem_led), .REF_SEL_EXT_O(external_ref_tag));
  fpmc_operator i_op (.clk_i(mclk), .sw_o(sw));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    @(negedge mclk);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
    @(posedge mclk);
  endtask : chk

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    awaddr <= a | 12'($random(seed) & 3); wdata <= v; wstrb <= 4'($random(seed)) | 4'h1;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge mclk);
      aw_t = awvalid & awready; w_t = wvalid & wready; b_t = bvalid; rs = bresp;
      @(posedge mclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar_t, r_t;
    araddr <= a | 12'($random(seed) & 3); arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge mclk);
      ar_t = arvalid & arready; r_t = rvalid; v = rdata; rs = rresp;
      @(posedge mclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask : axi_rd

  function automatic int gnext(int v, int cur, bit up);
    int s;
    s = (cur == 0) ? 100 : (cur == 1) ? 10 : 5;
    v = up ? v + s : v - s;
    return (v > 300) ? 300 : (v < 0) ? 0 : v;
  endfunction : gnext

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    errors++;
    finish_test();
  end

  initial begin
    seed = 26; errors = 0; cmp_count = 0; rst_n = 1'b0; lo_lock = 2'h3; ext_low = 1'b0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h0;
    nv_in = fpmc_settings_t'($random(seed));
    nv_in.gain = 10'(($random(seed) & 32'h7fffffff) % 301);
    nv_in.mute = 1'b0;
    nv_in.remote_en = 1'b1;
    nv_in.ref_mode = REF_AUTO;
    saved = nv_in;
    live = nv_in;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(sets, nv_in);
    chk(disp.phase, PH_RUN);
    chk(rem_led, 1'b1);
    chk(disp.tag, TAG_AUTO_E);
    $display("power-up done");
    i_op.press(0);
    chk(disp.state, ST_EDIT);
    for (c = 0; c < 3; c++) begin
      i_op.press(c == 2 ? 4 : 3);
      g = gnext(live.gain, c, c != 2);
      live.gain = 10'(g);
      chk(sets, live);
      chk(nv_out, saved);
      i_op.press(2);
      chk(disp.cursor, c + 1);
    end
    i_op.press(1);
    chk(disp.cursor, 2);
    i_op.press(2);
    i_op.press(0);
    chk(disp.state, ST_SAVE);
    i_op.press(3);
    chk(disp.save_yes, 1'b1);
    i_op.press(0);
    saved = live;
    chk(nv_out, saved);
    chk(disp.state, ST_IDLE);
    $display("gain edit done");
    i_op.press(0);
    i_op.press(4);
    live.gain = 10'(gnext(live.gain, 0, 1'b0));
    i_op.press(0);
    chk(disp.item, IT_MUTE);
    i_op.press(4);
    live.mute = 1'b1;
    chk(sets, live);
    i_op.press(3);
    live.mute = 1'b0;
    chk(sets, live);
    for (c = 2; c < 7; c++) begin
      i_op.press(0);
      chk(disp.item, c);
      if (c == 2) begin
        i_op.press(4);
        chk(disp.tag, TAG_EXT);
        i_op.press(4);
        chk(external_ref_tag, 1'b0);
        chk(disp.tag, TAG_INT);
      end
      if (c == 3) begin
        i_op.press(3);
        g = live.ref_offset + 100;
        chk(sets.ref_offset, 12'((g > 2000) ? 2000 : g));
      end
    end
    i_op.press(0);
    chk(disp.state, ST_SAVE);
    i_op.press(0);
    live = saved;
    chk(sets, saved);
    $display("menu walk done");
    i_op.press(0);
    i_op.press(3);
    live.gain = 10'(gnext(live.gain, 0, 1'b1));
    chk(sets, live);
    repeat (150) @(posedge mclk);
    chk(disp.state, ST_EDIT);
    repeat (100) @(posedge mclk);
    chk(disp.state, ST_IDLE);
    chk(sets, saved);
    $display("timeout done");
    axi_wr(REG_CTRL, 32'($random(seed)) | 32'h1, r);
    chk(r, RESP_OKAY);
    axi_rd(REG_CTRL, d, r);
    chk(d[0], 1'b1);
    i_op.press(0);
    chk(disp.state, ST_IDLE);
    axi_wr(REG_CTRL, 32'($random(seed)) & 32'hfffffffe, r);
    axi_rd(12'h010, d, r);
    chk(r, RESP_SLVERR);
    axi_rd(REG_LIVE, d, r);
    chk(d, saved);
    ext_low <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(external_ref_tag, 1'b1);
    repeat (20) @(posedge mclk);
    chk(external_ref_tag, 1'b0);
    chk(disp.tag, TAG_AUTO_I);
    lo_lock <= 2'($unsigned($random(seed)) % 3);
    repeat (10) @(posedge mclk);
    chk(alarm & alarm_led, 1'b1);
    $display("bus and reference done");
    finish_test();
  end
endmodule : tb_front_panel_menu_control
`default_nettype wire
